/* File: logic/lbc_band_lock.v */
// band lookup, lock enforcement, key selection and credential gate
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "lbc_map.vh"
// Summary of operation
// - cipher engine always on, 256-bit key
// - keys internal, never readable; random once enabled (bands 2-31) or erased
// - keys leave block only toward the cipher, on a grant
// - distinct key per each of 32 bands, except bands 0 and 1, which share the zero key until erased
// - security commands need proper credential
// - admin authority toggles download, owner/factory
// - locking authority: erase or band credential
// - all credentials start as factory default
// - hardware random source feeds keys, host
// - power loss locks band if relock, read and write are all armed
// - locked band refuses media reads writes
// - download path starts unlocked
// - band 0 covers whatever no other band holds
// - band 1 range carved from global band
// - bands 2-31 need erase-credential enable first
// - reject overlaps, adjacent ranges allowed
// - crypto erase replaces key, no history
// - firmware accepted only if three checks pass
// - sanitize 0x48 action 3 erases key
module lbc_band_lock #(
  parameter NBANDS = 32,
  parameter LBAW = 32,
  parameter KEYW = 256,
  parameter [31:0] FACTORY_CRED = `LBC_FACTORY_CRED
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // avalon-mm slave
  input wire [7:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  // power loss event pin
  input wire powerLossEvent,
  // media request from command path
  input wire mediaReqValid,
  input wire mediaReqWrite,
  input wire [LBAW-1:0] mediaReqLba,
  input wire [LBAW-1:0] mediaReqCount,
  // sanitize command decode
  input wire sanitizeValid,
  input wire [7:0] sanitizeOpcode,
  input wire [4:0] sanitizeAction,
  // answer to cipher engine and command path
  output reg mediaGrant,
  output reg mediaDeny,
  output reg [4:0] mediaBand,
  output reg [KEYW-1:0] bandDataKey,
  output wire cipherEnable
);

  localparam BW = 5;

  // band table
  reg [LBAW-1:0] bandStart_r [0:NBANDS-1];
  reg [LBAW-1:0] bandLen_r [0:NBANDS-1];
  reg [KEYW-1:0] bandKey_r [0:NBANDS-1];
  reg [NBANDS-1:0] bandEn_r;
  reg [NBANDS-1:0] relock_r;
  reg [NBANDS-1:0] rdArm_r;
  reg [NBANDS-1:0] wrArm_r;
  reg [NBANDS-1:0] locked_r;
  reg [31:0] bandCred_r [0:NBANDS-1];
  // credentials and staged command operands
  reg [31:0] ownerCred_r;
  reg [31:0] eraseCred_r;
  reg [31:0] credIn_r;
  reg [BW-1:0] bandSel_r;
  reg [LBAW-1:0] startIn_r;
  reg [LBAW-1:0] lenIn_r;
  reg [3:0] cfgIn_r;
  reg [LBAW-1:0] maxLba_r;
  // authorities held, dropped by logout or power loss
  reg adminAuth_r;
  reg eraseAuth_r;
  reg bandAuth_r;
  reg [BW-1:0] bandAuthIdx_r;
  reg fwEnable_r;
  reg [2:0] fwChecks_r;
  reg fwAccept_r;
  // outcome flags of the last command
  reg reject_r;
  reg overlap_r;
  // random source, power-loss synchroniser and read phase
  reg [31:0] lfsr_r;
  reg pl1_r;
  reg pl2_r;
  reg pl3_r;
  reg rdPend_r;
  // one loop index per process keeps every variable single-driven
  integer i;
  integer j;
  integer n;

  // single-cycle answer: waitrequest only during the read fetch cycle
  assign avsWaitRequest = avsRead & ~rdPend_r;
  assign cipherEnable = 1'b1;

  // one step of a 32-bit maximal lfsr
  function [31:0] lfsrStep;
    input [31:0] s;
    begin
      lfsrStep = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
  endfunction

  // fresh 256-bit key from the random state and a band index
  function [KEYW-1:0] newKey;
    input [31:0] s;
    input [BW-1:0] b;
    integer k;
    begin
      newKey = {KEYW{1'b0}};
      for (k = 0; k < KEYW / 32; k = k + 1) begin
        newKey[k*32 +: 32] = s ^ {27'h0, b} ^ (32'h9e37_79b9 * (k + 1));
      end
    end
  endfunction

  // does [s, s+l-1] touch [a, a+m-1]; adjacent ranges do not
  function rangeHit;
    input [LBAW-1:0] s;
    input [LBAW-1:0] l;
    input [LBAW-1:0] a;
    input [LBAW-1:0] m;
    begin
      rangeHit = (l != 0) && (m != 0) && ({1'b0, s} < {1'b0, a} + m) && ({1'b0, a} < {1'b0, s} + l);
    end
  endfunction

  // overlap of the staged range with any other enabled band
  reg overlapHit;
  always @* begin
    overlapHit = 1'b0;
    // band 0 is the remainder and never collides
    for (i = 1; i < NBANDS; i = i + 1) begin
      if (bandEn_r[i] && i[BW-1:0] != bandSel_r && rangeHit(startIn_r, lenIn_r, bandStart_r[i], bandLen_r[i]))
        overlapHit = 1'b1;
    end
  end

  // band lookup for the media request; default is the global band
  reg [BW-1:0] hitBand;
  reg spans;
  always @* begin
    hitBand = {BW{1'b0}};
    spans = 1'b0;
    // a later band wins, but a request in two bands is flagged spanning anyway
    for (j = 1; j < NBANDS; j = j + 1) begin
      if (bandEn_r[j] && bandLen_r[j] != 0 &&
          rangeHit(mediaReqLba, mediaReqCount, bandStart_r[j], bandLen_r[j])) begin
        hitBand = j[BW-1:0];
        // a request straddling a boundary needs two keys, refuse it
        if (mediaReqLba < bandStart_r[j] ||
            {1'b0, mediaReqLba} + mediaReqCount > {1'b0, bandStart_r[j]} + bandLen_r[j])
          spans = 1'b1;
      end
    end
  end

  // command strobe, and the locking authority over the selected band
  wire cmdWr = avsWrite && avsAddress == `LBC_REG_CMD && avsByteEnable[0];
  wire [3:0] cmdCode = avsWriteData[3:0];
  wire locking = eraseAuth_r || (bandAuth_r && bandAuthIdx_r == bandSel_r);
  wire sanErase = sanitizeValid && sanitizeOpcode == `LBC_SANITIZE_OP &&
                  sanitizeAction == `LBC_SA_CRYPTO_ERASE;
  wire plEdge = pl2_r & ~pl3_r;

  // media answer, registered
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mediaGrant <= 1'b0;
      mediaDeny <= 1'b0;
      mediaBand <= 5'h00;
      bandDataKey <= {KEYW{1'b0}};
    end else begin
      mediaGrant <= mediaReqValid && !spans && !locked_r[hitBand];
      mediaDeny <= mediaReqValid && (spans || locked_r[hitBand]);
      mediaBand <= hitBand;
      // key goes only to the cipher engine, never to the bus
      // a refused request, split or locked, must not carry any key out
      bandDataKey <= (mediaReqValid && !spans && !locked_r[hitBand]) ? bandKey_r[hitBand]
                     : {KEYW{1'b0}};
    end
  end

  // bus read mux; keys are never mapped
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avsReadData <= 32'h0;
      rdPend_r <= 1'b0;
    end else begin
      rdPend_r <= avsRead & ~rdPend_r;
      // load only in the fetch cycle, so the word holds until the next read
      // and the free-running random word does not drift under the master
      if (avsRead && !rdPend_r) begin
        case (avsAddress)
          `LBC_REG_STATUS: avsReadData <= {26'h0, overlap_r, reject_r, fwEnable_r, bandAuth_r, eraseAuth_r,
                                           adminAuth_r};
          `LBC_REG_BAND_SEL: avsReadData <= {27'h0, bandSel_r};
          `LBC_REG_BAND_START: avsReadData <= bandStart_r[bandSel_r];
          `LBC_REG_BAND_LEN: avsReadData <= bandLen_r[bandSel_r];
          `LBC_REG_BAND_CFG: avsReadData <= {27'h0, bandEn_r[bandSel_r], locked_r[bandSel_r], wrArm_r[bandSel_r],
                                             rdArm_r[bandSel_r], relock_r[bandSel_r]};
          `LBC_REG_RNG: avsReadData <= lfsr_r;
          `LBC_REG_FW: avsReadData <= {28'h0, fwAccept_r, fwChecks_r};
          `LBC_REG_MAXLBA: avsReadData <= maxLba_r;
          // factory default credential readable electronically only here
          `LBC_REG_CRED: avsReadData <= FACTORY_CRED;
          default: avsReadData <= 32'h0;
        endcase
      end
    end
  end

  // power-loss pin synchroniser and random source
  // the lfsr is a stand-in; a product needs a true entropy source
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pl1_r <= 1'b0;
      pl2_r <= 1'b0;
      pl3_r <= 1'b0;
      lfsr_r <= 32'h1;
    end else begin
      pl1_r <= powerLossEvent;
      pl2_r <= pl1_r;
      pl3_r <= pl2_r;
      lfsr_r <= lfsrStep(lfsr_r);
    end
  end

  // security state, band table and command execution
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ownerCred_r <= FACTORY_CRED;
      eraseCred_r <= FACTORY_CRED;
      credIn_r <= 32'h0;
      bandSel_r <= {BW{1'b0}};
      startIn_r <= {LBAW{1'b0}};
      lenIn_r <= {LBAW{1'b0}};
      cfgIn_r <= 4'h0;
      maxLba_r <= {LBAW{1'b1}};
      adminAuth_r <= 1'b0;
      eraseAuth_r <= 1'b0;
      bandAuth_r <= 1'b0;
      bandAuthIdx_r <= {BW{1'b0}};
      fwEnable_r <= 1'b1;
      fwChecks_r <= 3'h0;
      fwAccept_r <= 1'b0;
      reject_r <= 1'b0;
      overlap_r <= 1'b0;
      bandEn_r <= {{(NBANDS-2){1'b0}}, 2'b11};
      relock_r <= {NBANDS{1'b0}};
      rdArm_r <= {NBANDS{1'b0}};
      wrArm_r <= {NBANDS{1'b0}};
      locked_r <= {NBANDS{1'b0}};
      for (n = 0; n < NBANDS; n = n + 1) begin
        bandCred_r[n] <= FACTORY_CRED;
        bandStart_r[n] <= {LBAW{1'b0}};
        bandLen_r[n] <= {LBAW{1'b0}};
        // real keys come from the random source; bands 0 and 1 use this zero key until a crypto erase
        bandKey_r[n] <= {KEYW{1'b0}};
      end
    end else begin
      // power loss locks only fully armed bands
      if (plEdge) begin
        locked_r <= locked_r | (relock_r & rdArm_r & wrArm_r);
        adminAuth_r <= 1'b0;
        eraseAuth_r <= 1'b0;
        bandAuth_r <= 1'b0;
      end
      if (sanErase)
        bandKey_r[bandSel_r] <= newKey(lfsr_r, bandSel_r);
      if (avsWrite && avsByteEnable == 4'hf) begin
        case (avsAddress)
          `LBC_REG_CRED: credIn_r <= avsWriteData;
          `LBC_REG_BAND_SEL: bandSel_r <= avsWriteData[BW-1:0];
          `LBC_REG_BAND_START: startIn_r <= avsWriteData[LBAW-1:0];
          `LBC_REG_BAND_LEN: lenIn_r <= avsWriteData[LBAW-1:0];
          `LBC_REG_BAND_CFG: cfgIn_r <= avsWriteData[3:0];
          `LBC_REG_FW: begin
            fwChecks_r <= avsWriteData[2:0];
            // sed image, signature and model must all pass
            fwAccept_r <= fwEnable_r && (&avsWriteData[2:0]);
          end
          `LBC_REG_MAXLBA: maxLba_r <= avsWriteData[LBAW-1:0];
          default: ;
        endcase
      end
      // a command on the power-loss edge is dropped, so an unlock cannot undo the relock
      if (cmdWr && !plEdge) begin
        reject_r <= 1'b0;
        overlap_r <= 1'b0;
        case (cmdCode)
          `LBC_CMD_AUTH_ADMIN: begin
            adminAuth_r <= credIn_r == ownerCred_r || credIn_r == FACTORY_CRED;
            reject_r <= !(credIn_r == ownerCred_r || credIn_r == FACTORY_CRED);
          end
          `LBC_CMD_AUTH_ERASE: begin
            eraseAuth_r <= credIn_r == eraseCred_r;
            reject_r <= credIn_r != eraseCred_r;
          end
          `LBC_CMD_AUTH_BAND: begin
            bandAuth_r <= credIn_r == bandCred_r[bandSel_r];
            bandAuthIdx_r <= bandSel_r;
            reject_r <= credIn_r != bandCred_r[bandSel_r];
          end
          `LBC_CMD_SET_CRED: begin
            // new credential for the authority currently held
            if (adminAuth_r) ownerCred_r <= credIn_r;
            else if (eraseAuth_r) eraseCred_r <= credIn_r;
            else if (locking) bandCred_r[bandSel_r] <= credIn_r;
            else reject_r <= 1'b1;
          end
          `LBC_CMD_FW_ENABLE, `LBC_CMD_FW_DISABLE: begin
            if (adminAuth_r) fwEnable_r <= cmdCode == `LBC_CMD_FW_ENABLE;
            else reject_r <= 1'b1;
          end
          `LBC_CMD_BAND_ENABLE: begin
            // a fresh key on enable leaves nothing readable from earlier use
            if (eraseAuth_r && bandSel_r > 1) begin
              bandEn_r[bandSel_r] <= 1'b1;
              bandKey_r[bandSel_r] <= newKey(lfsr_r, bandSel_r);
            end else reject_r <= 1'b1;
          end
          `LBC_CMD_BAND_RANGE: begin
            // band 0 is the remainder and takes no range of its own
            if (!locking || bandSel_r == 0 || !bandEn_r[bandSel_r]) reject_r <= 1'b1;
            else if (overlapHit || {1'b0, startIn_r} + lenIn_r > {1'b0, maxLba_r} + 1'b1) begin
              reject_r <= 1'b1;
              overlap_r <= 1'b1;
            end else begin
              bandStart_r[bandSel_r] <= startIn_r;
              bandLen_r[bandSel_r] <= lenIn_r;
            end
          end
          `LBC_CMD_CRYPTO_ERASE: begin
            if (locking) bandKey_r[bandSel_r] <= newKey(lfsr_r, bandSel_r);
            else reject_r <= 1'b1;
          end
          `LBC_CMD_UNLOCK: begin
            if (locking) locked_r[bandSel_r] <= 1'b0;
            else reject_r <= 1'b1;
          end
          `LBC_CMD_LOCK_CFG: begin
            if (locking) begin
              relock_r[bandSel_r] <= cfgIn_r[`LBC_CFG_RELOCK];
              rdArm_r[bandSel_r] <= cfgIn_r[`LBC_CFG_RDARM];
              wrArm_r[bandSel_r] <= cfgIn_r[`LBC_CFG_WRARM];
              if (cfgIn_r[`LBC_CFG_LOCKED]) locked_r[bandSel_r] <= 1'b1;
            end else reject_r <= 1'b1;
          end
          `LBC_CMD_LOGOUT: begin
            adminAuth_r <= 1'b0;
            eraseAuth_r <= 1'b0;
            bandAuth_r <= 1'b0;
          end
          default: reject_r <= 1'b1;
        endcase
      end
    end
  end

endmodule // lbc_band_lock

/* File: logic/lbc_map.vh */
// register offsets, fields and constants of the band lock and key select block
`ifndef LBC_MAP_VH
`define LBC_MAP_VH
// register byte offsets (one aligned 32-bit word each)
`define LBC_REG_CTRL 8'h00
`define LBC_REG_STATUS 8'h04
`define LBC_REG_CRED 8'h08
`define LBC_REG_CMD 8'h0c
`define LBC_REG_BAND_SEL 8'h10
`define LBC_REG_BAND_START 8'h14
`define LBC_REG_BAND_LEN 8'h18
`define LBC_REG_BAND_CFG 8'h1c
`define LBC_REG_RNG 8'h20
`define LBC_REG_FW 8'h24
`define LBC_REG_MAXLBA 8'h28
// command codes written to CMD
`define LBC_CMD_AUTH_ADMIN 4'h1
`define LBC_CMD_AUTH_ERASE 4'h2
`define LBC_CMD_AUTH_BAND 4'h3
`define LBC_CMD_SET_CRED 4'h4
`define LBC_CMD_FW_ENABLE 4'h5
`define LBC_CMD_FW_DISABLE 4'h6
`define LBC_CMD_BAND_ENABLE 4'h7
`define LBC_CMD_BAND_RANGE 4'h8
`define LBC_CMD_CRYPTO_ERASE 4'h9
`define LBC_CMD_UNLOCK 4'ha
`define LBC_CMD_LOCK_CFG 4'hb
`define LBC_CMD_LOGOUT 4'hc
// status bits
`define LBC_ST_ADMIN 0
`define LBC_ST_ERASE 1
`define LBC_ST_BAND 2
`define LBC_ST_FWEN 3
`define LBC_ST_REJECT 4
`define LBC_ST_OVERLAP 5
// band config bits
`define LBC_CFG_RELOCK 0
`define LBC_CFG_RDARM 1
`define LBC_CFG_WRARM 2
`define LBC_CFG_LOCKED 3
`define LBC_CFG_EN 4
// firmware check bits
`define LBC_FW_SED 0
`define LBC_FW_SIG 1
`define LBC_FW_MODEL 2
// sanitize opcode and crypto erase service action
`define LBC_SANITIZE_OP 8'h48
`define LBC_SA_CRYPTO_ERASE 5'h03
// factory default credential word, arbitrary
`define LBC_FACTORY_CRED 32'h5a3c_96e1
`endif

/* File: sim/lbc_band_lock_asserts.sv */
// port checks for the band lock and key select block
`timescale 1ns/1ps
module lbc_band_lock_asserts #(
  parameter KEYW = 256
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // register bus
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsReadData,
  input wire avsWaitRequest,
  // media answer
  input wire mediaReqValid,
  input wire mediaGrant,
  input wire mediaDeny,
  input wire [4:0] mediaBand,
  input wire [KEYW-1:0] bandDataKey,
  input wire cipherEnable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // cipher can never be switched off
  a_cipher_always_on: assert property (cipherEnable)
    else $error("cipher engine disabled");
  // every request gets exactly one answer next cycle
  a_media_answer: assert property (mediaReqValid |=> mediaGrant ^ mediaDeny)
    else $error("media request not answered once");
  a_media_quiet: assert property (!mediaReqValid |=> !mediaGrant && !mediaDeny)
    else $error("media answer without request");
  // key only leaves toward the engine on a grant
  a_key_hidden: assert property (!mediaGrant |-> bandDataKey == '0)
    else $error("key visible without grant");
  // reads wait exactly one cycle, writes never
  a_read_wait: assert property ($rose(avsRead) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (avsWrite |-> !avsWaitRequest)
    else $error("write stalled");
  a_idle_nowait: assert property (!avsRead |-> !avsWaitRequest)
    else $error("wait without read");
  a_read_hold: assert property (!avsRead |=> $stable(avsReadData))
    else $error("read data changed while idle");
  cover property (mediaGrant && mediaBand == 5'h02);
  cover property (mediaDeny);
  cover property (avsRead && !avsWaitRequest);
endmodule // lbc_band_lock_asserts
bind lbc_band_lock lbc_band_lock_asserts #(.KEYW(KEYW)) u_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .avsRead(avsRead),
  .avsWrite(avsWrite),
  .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest),
  .mediaReqValid(mediaReqValid),
  .mediaGrant(mediaGrant),
  .mediaDeny(mediaDeny),
  .mediaBand(mediaBand),
  .bandDataKey(bandDataKey),
  .cipherEnable(cipherEnable)
);

/* File: sim/lbc_host_model.sv */
// host initiator model: register bus master, media, sanitize and power pins
`timescale 1ns/1ps
`include "lbc_map.vh"
module lbc_host_model (
  // clock
  input wire core_clk,
  // register bus master
  output logic [7:0] avsAddress,
  output logic avsRead,
  output logic avsWrite,
  output logic [31:0] avsWriteData,
  output logic [3:0] avsByteEnable,
  input wire [31:0] avsReadData,
  input wire avsWaitRequest,
  // media, sanitize and power
  output logic mediaReqValid,
  output logic mediaReqWrite,
  output logic [31:0] mediaReqLba,
  output logic [31:0] mediaReqCount,
  output logic sanitizeValid,
  output logic [7:0] sanitizeOpcode,
  output logic [4:0] sanitizeAction,
  output logic powerLossEvent
);
  // idle levels at time zero
  initial begin
    {avsRead, avsWrite, mediaReqValid, mediaReqWrite, sanitizeValid, powerLossEvent} = 6'h00;
    avsAddress = 8'h00;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hf;
    mediaReqLba = 32'h0;
    mediaReqCount = 32'h0;
    sanitizeOpcode = 8'h00;
    sanitizeAction = 5'h00;
  end
  // security payloads only travel as register commands
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= 1'b1;
    do @(posedge core_clk); while (avsWaitRequest === 1'b1);
    avsWrite <= 1'b0;
    avsWriteData <= ~d; // released data must not linger
  endtask
  task automatic busRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsRead <= 1'b1;
    do @(posedge core_clk); while (avsWaitRequest === 1'b1);
    d = avsReadData;
    avsRead <= 1'b0;
    avsAddress <= ~a;
  endtask
  task automatic issue(input logic [3:0] c);
    busWrite(`LBC_REG_CMD, {28'h0, c});
  endtask
  // callers keep starts on 4096-block multiples
  task automatic setRange(input logic [4:0] b, input logic [31:0] s, input logic [31:0] l);
    busWrite(`LBC_REG_BAND_SEL, {27'h0, b});
    busWrite(`LBC_REG_BAND_START, s);
    busWrite(`LBC_REG_BAND_LEN, l);
    issue(`LBC_CMD_BAND_RANGE);
  endtask
  // one-cycle request, returns at the edge the block takes it
  task automatic media(input logic [31:0] lba, input logic [31:0] cnt, input logic wr);
    @(posedge core_clk);
    mediaReqLba <= lba;
    mediaReqCount <= cnt;
    mediaReqWrite <= wr;
    mediaReqValid <= 1'b1;
    @(posedge core_clk);
    mediaReqValid <= 1'b0;
    mediaReqLba <= ~lba;
  endtask
  task automatic sanitize(input logic [7:0] op, input logic [4:0] act);
    @(posedge core_clk);
    sanitizeOpcode <= op;
    sanitizeAction <= act;
    sanitizeValid <= 1'b1;
    @(posedge core_clk);
    sanitizeValid <= 1'b0;
  endtask
  // held a few cycles so the synchroniser sees it
  task automatic powerLoss;
    @(posedge core_clk);
    powerLossEvent <= 1'b1;
    repeat (3) @(posedge core_clk);
    powerLossEvent <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // lbc_host_model

/* File: sim/lbc_band_lock_tb_top.sv */
// self-checking bench for the band lock and key select block
`timescale 1ns/1ps
`include "lbc_map.vh"
module lbc_band_lock_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  wire [31:0] avsWriteData, avsReadData, mediaReqLba, mediaReqCount;
  wire [7:0] avsAddress, sanitizeOpcode;
  wire [4:0] sanitizeAction, mediaBand;
  wire [3:0] avsByteEnable;
  wire [255:0] bandDataKey;
  wire avsRead, avsWrite, avsWaitRequest, mediaReqValid, mediaReqWrite, sanitizeValid, powerLossEvent;
  wire mediaGrant, mediaDeny, cipherEnable;
  int failures = 0;
  int cmp_count = 0;
  logic [31:0] rdv;
  logic [255:0] keyA;
  // 250 MHz clock, reset for four cycles
  always #2 core_clk = ~core_clk;
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
  end
  lbc_host_model host (.core_clk(core_clk), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .mediaReqValid(mediaReqValid), .mediaReqWrite(mediaReqWrite),
    .mediaReqLba(mediaReqLba), .mediaReqCount(mediaReqCount), .sanitizeValid(sanitizeValid),
    .sanitizeOpcode(sanitizeOpcode), .sanitizeAction(sanitizeAction), .powerLossEvent(powerLossEvent));
  lbc_band_lock DUT (.core_clk(core_clk), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .powerLossEvent(powerLossEvent), .mediaReqValid(mediaReqValid),
    .mediaReqWrite(mediaReqWrite), .mediaReqLba(mediaReqLba), .mediaReqCount(mediaReqCount),
    .sanitizeValid(sanitizeValid), .sanitizeOpcode(sanitizeOpcode), .sanitizeAction(sanitizeAction),
    .mediaGrant(mediaGrant), .mediaDeny(mediaDeny), .mediaBand(mediaBand), .bandDataKey(bandDataKey),
    .cipherEnable(cipherEnable));
  // compare helpers
  task automatic cmpWord(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmpBit(input string n, input logic e, input logic g);
    cmpWord(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic expStatus(input logic [31:0] m, input logic [31:0] e, input string n);
    host.busRead(`LBC_REG_STATUS, rdv);
    cmpWord(n, e, rdv & m);
  endtask
  // answer lands one edge after the request; read after it settles
  task automatic checkMedia(input logic [31:0] lba, input logic [31:0] cnt, input logic wr, input logic g,
      input logic [4:0] b);
    host.media(lba, cnt, wr);
    #1;
    cmpBit("mediaGrant", g, mediaGrant);
    cmpBit("mediaDeny", !g, mediaDeny);
    if (g) cmpWord("mediaBand", {27'h0, b}, {27'h0, mediaBand});
    if (!g) cmpBit("keyWithheld", 1'b1, bandDataKey === 256'h0);
  endtask
  task automatic t_factory;
    cmpBit("cipherEnable", 1'b1, cipherEnable);
    expStatus(32'h3f, 32'h08, "statusReset");
    host.busRead(`LBC_REG_CRED, rdv);
    cmpWord("factoryCred", `LBC_FACTORY_CRED, rdv);
    host.busRead(8'hfc, rdv);
    cmpWord("unmapped", 32'h0, rdv);
    checkMedia(32'hffff_0000, 32'h1, 1'b0, 1'b1, 5'h00);
  endtask
  task automatic t_auth;
    host.busWrite(`LBC_REG_CRED, ~`LBC_FACTORY_CRED);
    host.issue(`LBC_CMD_AUTH_ADMIN);
    expStatus(32'h11, 32'h10, "badCred");
    host.busWrite(`LBC_REG_CRED, `LBC_FACTORY_CRED);
    host.issue(`LBC_CMD_AUTH_ADMIN);
    expStatus(32'h11, 32'h01, "adminAuth");
    host.issue(`LBC_CMD_FW_DISABLE);
    expStatus(32'h08, 32'h00, "fwOff");
    host.issue(`LBC_CMD_FW_ENABLE);
    expStatus(32'h08, 32'h08, "fwOn");
  endtask
  task automatic t_bands;
    host.issue(`LBC_CMD_AUTH_ERASE);
    host.setRange(5'h01, 32'h1000, 32'h1000);
    expStatus(32'h32, 32'h02, "band1Range");
    host.setRange(5'h02, 32'h2000, 32'h1000);
    expStatus(32'h10, 32'h10, "band2Disabled");
    host.issue(`LBC_CMD_BAND_ENABLE);
    host.setRange(5'h02, 32'h2000, 32'h1000);
    expStatus(32'h30, 32'h00, "adjacentBand");
    host.busWrite(`LBC_REG_BAND_SEL, 32'h3);
    host.issue(`LBC_CMD_BAND_ENABLE);
    host.setRange(5'h03, 32'h2000, 32'h1000);
    expStatus(32'h20, 32'h20, "overlap");
    checkMedia(32'h1000, 32'h1, 1'b0, 1'b1, 5'h01);
    checkMedia(32'h2fff, 32'h1, 1'b1, 1'b1, 5'h02);
    checkMedia(32'h0fff, 32'h1, 1'b0, 1'b1, 5'h00);
    checkMedia(32'h1ff0, 32'h20, 1'b0, 1'b0, 5'h00);
  endtask
  task automatic t_erase;
    checkMedia(32'h1000, 32'h1, 1'b0, 1'b1, 5'h01);
    keyA = bandDataKey;
    host.busWrite(`LBC_REG_BAND_SEL, 32'h1);
    host.sanitize(8'h47, 5'h03);
    host.sanitize(8'h48, 5'h02);
    checkMedia(32'h1000, 32'h1, 1'b0, 1'b1, 5'h01);
    cmpBit("keyKept", 1'b1, bandDataKey === keyA);
    host.sanitize(8'h48, 5'h03);
    checkMedia(32'h1000, 32'h1, 1'b0, 1'b1, 5'h01);
    cmpBit("keyReplaced", 1'b1, bandDataKey !== keyA);
    keyA = bandDataKey;
    checkMedia(32'h2000, 32'h1, 1'b0, 1'b1, 5'h02);
    cmpBit("keysDistinct", 1'b1, bandDataKey !== keyA);
  endtask
  task automatic t_relock;
    host.busWrite(`LBC_REG_BAND_SEL, 32'h2);
    host.busWrite(`LBC_REG_BAND_CFG, 32'h7);
    host.issue(`LBC_CMD_LOCK_CFG);
    host.busWrite(`LBC_REG_BAND_SEL, 32'h1);
    host.busWrite(`LBC_REG_BAND_CFG, 32'h3);
    host.issue(`LBC_CMD_LOCK_CFG);
    checkMedia(32'h2000, 32'h1, 1'b0, 1'b1, 5'h02);
    host.powerLoss();
    checkMedia(32'h2000, 32'h1, 1'b1, 1'b0, 5'h00);
    checkMedia(32'h1000, 32'h1, 1'b1, 1'b1, 5'h01);
    host.busWrite(`LBC_REG_BAND_SEL, 32'h2);
    host.issue(`LBC_CMD_UNLOCK);
    checkMedia(32'h2000, 32'h1, 1'b0, 1'b0, 5'h00);
    host.issue(`LBC_CMD_AUTH_ERASE);
    host.issue(`LBC_CMD_UNLOCK);
    checkMedia(32'h2000, 32'h1, 1'b0, 1'b1, 5'h02);
  endtask
  // every combination of the three image checks
  task automatic t_firmware;
    for (int v = 0; v < 8; v++) begin
      host.busWrite(`LBC_REG_FW, 32'(v));
      host.busRead(`LBC_REG_FW, rdv);
      cmpBit("fwAccept", v == 7, rdv[3]);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // whole run needs well under this span
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
  initial begin
    @(posedge reset_n);
    t_factory();
    t_auth();
    t_bands();
    t_erase();
    t_relock();
    t_firmware();
    tally_and_finish();
  end
endmodule // lbc_band_lock_tb_top
